// ### nand_copyback_host.sv
// The implementer's own choices: register access over Wishbone and the register offsets.
module nand_copyback_host
  import nand_host_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // flash pins
  output nand_pins_t       pins,
  input  wire logic [7:0]  io_in,
  input  wire logic        rb
);

  ctl_state_t r_reg;
  ctl_state_t r_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // byte-lane merge of a bus write
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] wr_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wr_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // starts a command or address byte cycle
  function automatic ctl_state_t issue_byte(input ctl_state_t s, input logic is_cmd, input logic [7:0] val);
    ctl_state_t t;
    t = s;
    t.pins.cle    = is_cmd;
    t.pins.ale    = ~is_cmd;
    t.pins.io_out = val;
    t.pins.io_oe  = 1'b1;
    t.pins.we_n   = 1'b0;
    t.cnt         = STROBE_CNT;
    t.st          = ST_WR;
    return t;
  endfunction : issue_byte

  // starts a data read cycle
  function automatic ctl_state_t issue_read(input ctl_state_t s);
    ctl_state_t t;
    t = s;
    t.pins.io_oe         = 1'b0;
    t.pins.read_enable_n = 1'b0;
    t.cnt                = STROBE_CNT;
    t.st                 = ST_RD;
    return t;
  endfunction : issue_read

  // enters the wait for ready/busy to rise
  function automatic ctl_state_t issue_wait(input ctl_state_t s);
    ctl_state_t t;
    t = s;
    t.cnt = BUSY_SETUP_CNT;
    t.st  = ST_WAIT;
    return t;
  endfunction : issue_wait

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------

  // bus slave, start decode and byte sequencer
  always_comb begin
    logic        plane_mismatch;
    logic        bus_wr;
    logic        start_req;
    logic [31:0] ctrl_wd;
    logic [31:0] status_word;
    op_t         req_op;
    logic [1:0]  req_planes;
    plane_mismatch = 1'b0;
    bus_wr         = 1'b0;
    start_req      = 1'b0;
    ctrl_wd        = 32'h0000_0000;
    status_word    = 32'h0000_0000;
    req_op         = OP_STATUS;
    req_planes     = 2'h0;
    r_next         = r_reg;
    r_next.ack     = 1'b0;
    r_next.pins.wp_n = r_reg.wp_rel;

    // status word seen by software
    status_word[ST_BUSY_BIT]      = (r_reg.st != ST_IDLE);
    status_word[ST_DONE_BIT]      = r_reg.done;
    status_word[ST_RB_BIT]        = rb;
    status_word[ST_PWR_BIT]       = r_reg.pwr_ok;
    status_word[ST_FAIL_BIT]      = r_reg.stat_byte[NST_FAIL];
    status_word[ST_PLANE_ERR_BIT] = r_reg.plane_err;
    status_word[ST_PFAIL_LSB +: 4] = r_reg.multi ? r_reg.stat_byte[NST_PFAIL_LSB +: 4] : 4'h0;
    status_word[ST_BYTE_LSB +: 8] = r_reg.stat_byte;

    // classic wishbone: one wait state, ack for one cycle
    if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
      r_next.ack = 1'b1;
      bus_wr     = wb_we_i;
      r_next.dat = 32'h0000_0000;
      case (wb_adr_i)
        REG_CTRL: begin
          r_next.dat[CTRL_OP_LSB +: 3]     = r_reg.op;
          r_next.dat[CTRL_PLANES_LSB +: 2] = r_reg.last_plane;
          r_next.dat[CTRL_WP_BIT]          = r_reg.wp_rel;
        end
        REG_STATUS: begin
          r_next.dat = status_word;
        end
        REG_ID: begin
          r_next.dat = r_reg.id;
        end
        default: begin
          if (wb_adr_i[7:4] == REG_SRC0[7:4] && wb_adr_i[1:0] == 2'h0) begin
            r_next.dat = r_reg.src[wb_adr_i[3:2]];
          end else if (wb_adr_i[7:4] == REG_DST0[7:4] && wb_adr_i[1:0] == 2'h0) begin
            r_next.dat = r_reg.dst[wb_adr_i[3:2]];
          end
        end
      endcase
    end

    // register writes
    if (bus_wr) begin
      if (wb_adr_i == REG_CTRL) begin
        ctrl_wd       = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
        req_op        = op_t'(ctrl_wd[CTRL_OP_LSB +: 3]);
        req_planes    = ctrl_wd[CTRL_PLANES_LSB +: 2];
        start_req     = ctrl_wd[CTRL_START_BIT] && r_reg.pwr_ok;
        if (wb_sel_i[1]) begin
          r_next.wp_rel = ctrl_wd[CTRL_WP_BIT];
        end
      end else if (wb_adr_i[7:4] == REG_SRC0[7:4] && r_reg.st == ST_IDLE) begin
        r_next.src[wb_adr_i[3:2]] = lane_merge(r_reg.src[wb_adr_i[3:2]], wb_dat_i, wb_sel_i);
      end else if (wb_adr_i[7:4] == REG_DST0[7:4] && r_reg.st == ST_IDLE) begin
        r_next.dst[wb_adr_i[3:2]] = lane_merge(r_reg.dst[wb_adr_i[3:2]], wb_dat_i, wb_sel_i);
      end
    end

    // same-plane check over every plane in use
    for (int i = 0; i < 4; i++) begin
      if (2'(i) <= req_planes) begin
        if (r_reg.src[i][ADDR_A14] != r_reg.dst[i][ADDR_A14] ||
            r_reg.src[i][ADDR_A15] != r_reg.dst[i][ADDR_A15] ||
            r_reg.src[i][ADDR_A26] != r_reg.dst[i][ADDR_A26]) begin
          plane_mismatch = 1'b1;
        end
      end
    end

    // a reset order aborts a running sequence at once
    if (start_req && req_op == OP_RESET && r_reg.st != ST_IDLE) begin
      r_next.pins.cle           = 1'b0;
      r_next.pins.ale           = 1'b0;
      r_next.pins.we_n          = 1'b1;
      r_next.pins.read_enable_n = 1'b1;
      r_next.pins.io_oe         = 1'b0;
      r_next.op                 = OP_RESET;
      r_next.step               = S_RST_CMD;
      r_next.done               = 1'b0;
      r_next.st                 = ST_NEXT;
    end else if (start_req && r_reg.st == ST_IDLE) begin
      r_next.plane_err = 1'b0;
      if (req_op == OP_COPYBACK && plane_mismatch) begin
        r_next.plane_err = 1'b1;
        r_next.done      = 1'b1;
      end else begin
        r_next.op         = req_op;
        r_next.last_plane = (req_op == OP_COPYBACK) ? req_planes : 2'h0;
        r_next.multi      = (req_op == OP_STATUS_MP) || (req_op == OP_COPYBACK && req_planes != 2'h0);
        r_next.plane      = 2'h0;
        r_next.byte_i     = 2'h0;
        r_next.done       = 1'b0;
        r_next.pins.ce_n  = 1'b0;
        r_next.st         = ST_NEXT;
        case (req_op)
          OP_COPYBACK:  r_next.step = S_SRC_CMD;
          OP_READ_ID:   r_next.step = S_ID_CMD;
          OP_RESET:     r_next.step = S_RST_CMD;
          default:      r_next.step = S_STAT_CMD;
        endcase
      end
    end else begin
      // byte sequencer
      case (r_reg.st)
        ST_PWR: begin
          if (r_reg.cnt == 10'h000) begin
            r_next.pwr_ok = 1'b1;
            r_next.st     = ST_IDLE;
          end else begin
            r_next.cnt = r_reg.cnt - 10'h001;
          end
        end
        ST_IDLE: begin
          r_next.pins.ce_n = 1'b1;
        end
        ST_NEXT: begin
          case (r_reg.step)
            S_SRC_CMD: begin
              // first plane opens with 00h, every later plane with 03h
              r_next = issue_byte(r_next, 1'b1, (r_reg.plane == 2'h0) ? CMD_READ_MAIN : CMD_READ_ALT);
              r_next.step = S_SRC_ADDR;
            end
            S_SRC_ADDR: begin
              r_next        = issue_byte(r_next, 1'b0, r_reg.src[r_reg.plane][r_reg.byte_i*8 +: 8]);
              r_next.byte_i = r_reg.byte_i + 2'h1;
              r_next.step   = (r_reg.byte_i == 2'h3) ? S_SRC_WAIT : S_SRC_ADDR;
            end
            S_SRC_WAIT: begin
              // page moves into the page register while busy
              r_next = issue_wait(r_next);
              if (r_reg.plane == r_reg.last_plane) begin
                r_next.plane = 2'h0;
                r_next.step  = S_DST_CMD;
              end else begin
                r_next.plane = r_reg.plane + 2'h1;
                r_next.step  = S_SRC_CMD;
              end
            end
            S_DST_CMD: begin
              r_next      = issue_byte(r_next, 1'b1, CMD_COPY_DATA_IN);
              r_next.step = S_DST_ADDR;
            end
            S_DST_ADDR: begin
              r_next        = issue_byte(r_next, 1'b0, r_reg.dst[r_reg.plane][r_reg.byte_i*8 +: 8]);
              r_next.byte_i = r_reg.byte_i + 2'h1;
              r_next.step   = (r_reg.byte_i == 2'h3) ? S_DST_CONF : S_DST_ADDR;
            end
            S_DST_CONF: begin
              // dummy 11h between planes, true 10h on the last one
              r_next = issue_byte(r_next, 1'b1,
                                  (r_reg.plane == r_reg.last_plane) ? CMD_PROG_CONFIRM : CMD_PROG_DUMMY);
              r_next.step = S_DST_WAIT;
            end
            S_DST_WAIT: begin
              r_next = issue_wait(r_next);
              if (r_reg.plane == r_reg.last_plane) begin
                r_next.step = S_STAT_CMD;
              end else begin
                r_next.plane = r_reg.plane + 2'h1;
                r_next.step  = S_DST_CMD;
              end
            end
            S_STAT_CMD: begin
              r_next      = issue_byte(r_next, 1'b1, r_reg.multi ? CMD_STATUS_MP : CMD_STATUS);
              r_next.step = S_STAT_RD;
            end
            S_STAT_RD: begin
              r_next      = issue_read(r_next);
              r_next.step = S_FINISH;
            end
            S_ID_CMD: begin
              r_next      = issue_byte(r_next, 1'b1, CMD_READ_ID);
              r_next.step = S_ID_ADDR;
            end
            S_ID_ADDR: begin
              r_next        = issue_byte(r_next, 1'b0, ID_ADDR);
              r_next.byte_i = 2'h0;
              r_next.step   = S_ID_RD;
            end
            S_ID_RD: begin
              r_next        = issue_read(r_next);
              r_next.byte_i = r_reg.byte_i + 2'h1;
              r_next.step   = (r_reg.byte_i == 2'h3) ? S_FINISH : S_ID_RD;
            end
            S_RST_CMD: begin
              r_next      = issue_byte(r_next, 1'b1, CMD_RESET);
              r_next.step = S_RST_WAIT;
            end
            S_RST_WAIT: begin
              // device idles afterwards, so nothing more is sent
              r_next      = issue_wait(r_next);
              r_next.step = S_FINISH;
            end
            default: begin
              r_next.pins.ce_n = 1'b1;
              r_next.done      = 1'b1;
              r_next.st        = ST_IDLE;
            end
          endcase
        end
        ST_WR: begin
          if (r_reg.cnt == 10'h000) begin
            r_next.pins.we_n = 1'b1;
            r_next.cnt       = STROBE_CNT;
            r_next.st        = ST_WRH;
          end else begin
            r_next.cnt = r_reg.cnt - 10'h001;
          end
        end
        ST_WRH: begin
          if (r_reg.cnt == 10'h000) begin
            r_next.pins.cle   = 1'b0;
            r_next.pins.ale   = 1'b0;
            r_next.pins.io_oe = 1'b0;
            r_next.st         = ST_NEXT;
          end else begin
            r_next.cnt = r_reg.cnt - 10'h001;
          end
        end
        ST_RD: begin
          if (r_reg.cnt == 10'h000) begin
            // sample just before read enable rises
            if (r_reg.op == OP_READ_ID) begin
              r_next.id = {io_in, r_reg.id[31:8]};
            end else begin
              r_next.stat_byte = io_in;
            end
            r_next.pins.read_enable_n = 1'b1;
            r_next.cnt                = STROBE_CNT;
            r_next.st                 = ST_RDH;
          end else begin
            r_next.cnt = r_reg.cnt - 10'h001;
          end
        end
        ST_RDH: begin
          if (r_reg.cnt == 10'h000) begin
            r_next.st = ST_NEXT;
          end else begin
            r_next.cnt = r_reg.cnt - 10'h001;
          end
        end
        ST_WAIT: begin
          // let ready/busy fall first, then wait for it to rise
          if (r_reg.cnt != 10'h000) begin
            r_next.cnt = r_reg.cnt - 10'h001;
          end else if (rb) begin
            r_next.st = ST_NEXT;
          end
        end
        default: begin
          r_next.st = ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  // synchronous reset, power-up recovery count loaded
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r_reg      <= '0;
      r_reg.pins <= PINS_IDLE;
      r_reg.cnt  <= PWR_CNT_INIT;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign wb_dat_o = r_reg.dat;
  assign wb_ack_o = r_reg.ack;
  assign pins     = r_reg.pins;

endmodule : nand_copyback_host

// ### nand_copyback_host_chk.sv
module nand_copyback_host_chk
  import nand_host_pkg::*;
(
  // clock and reset
  input wire logic  sys_clk,
  input wire logic  rst_n,
  // bus handshake
  input wire logic  wb_cyc_i,
  input wire logic  wb_stb_i,
  input wire logic  wb_ack_o,
  // flash side
  input nand_pins_t pins,
  input wire logic  rb
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // -------------------------------------------
  // cycles since reset release, saturating
  // -------------------------------------------
  logic [9:0] up_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) up_reg <= '0;
    else if (up_reg != 10'h3ff) up_reg <= up_reg + 10'h001;
  end

  // -------------------------------------------
  // properties
  // -------------------------------------------
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_pwr_wait;
    up_reg < 10'(PWR_RECOVERY_CYC) |-> pins.ce_n;
  endproperty
  a_pwr_wait: assert property (p_pwr_wait) else $error("command too soon");
  property p_we_width;
    $fell(pins.we_n) |=> !pins.we_n ##1 pins.we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width");
  property p_we_data;
    !pins.we_n |-> pins.io_oe && !pins.ce_n;
  endproperty
  a_we_data: assert property (p_we_data) else $error("strobe without data");
  property p_re_width;
    $fell(pins.read_enable_n) |=> !pins.read_enable_n ##1 pins.read_enable_n[*2];
  endproperty
  a_re_width: assert property (p_re_width) else $error("read strobe width");
  property p_copy_ready;
    $fell(pins.we_n) && pins.cle && pins.io_out == CMD_COPY_DATA_IN |-> rb;
  endproperty
  a_copy_ready: assert property (p_copy_ready) else $error("copy cmd while busy");
  property p_id_addr;
    $fell(pins.we_n) && pins.cle && pins.io_out == CMD_READ_ID
      |=> ##[1:12] ($fell(pins.we_n) && pins.ale && pins.io_out == ID_ADDR);
  endproperty
  a_id_addr: assert property (p_id_addr) else $error("id address missing");
  property p_read_addr;
    $fell(pins.we_n) && pins.cle && pins.io_out == CMD_READ_MAIN |=> ##[1:12] ($fell(pins.we_n) && pins.ale);
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("source address missing");

  // main scenarios reached
  c_copy: cover property ($fell(pins.we_n) && pins.cle && pins.io_out == CMD_COPY_DATA_IN);
  c_mp: cover property ($fell(pins.we_n) && pins.cle && pins.io_out == CMD_STATUS_MP);
  c_rst: cover property ($fell(pins.we_n) && pins.cle && pins.io_out == CMD_RESET);
endmodule : nand_copyback_host_chk

// ### nand_copyback_host_tb_top.sv
module nand_copyback_host_tb_top
  import nand_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] ctrl; logic [7:0] adr; logic [31:0] mask; logic [31:0] exp;} row_t;
  logic        sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rb, fail_en;
  logic [3:0]  wb_sel_i;
  logic [7:0]  wb_adr_i, io_in;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  nand_pins_t  pins;
  int          errors, checked, i;
  row_t        rows [5];

  nand_copyback_host uut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pins(pins), .io_in(io_in), .rb(rb));
  nand_dev_model mdl (.sys_clk(sys_clk), .pins(pins), .fail_en(fail_en), .io_in(io_in), .rb(rb));

  // --------------------------------------
  // clock, tasks
  // --------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic stop_test;
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) begin
      errors++;
      stop_test();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask : wb

  // start an operation, poll done, then read the result register
  task automatic run(input row_t r);
    int n;
    n = 0;
    wb(1'b1, REG_CTRL, r.ctrl, rd);
    do begin
      wb(1'b0, REG_STATUS, 32'h0000_0000, rd);
      n++;
    end while (rd[ST_DONE_BIT] !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      errors++;
      stop_test();
    end
    wb(1'b0, r.adr, 32'h0000_0000, rd);
    check(rd & r.mask, r.exp);
  endtask : run

  // --------------------------------------
  // main sequence
  // --------------------------------------
  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, fail_en} = '0;
    {wb_adr_i, wb_dat_i, errors, checked} = '0;
    wb_sel_i = 4'hf;
    rows[0] = '{32'h0000_0101, REG_STATUS, 32'h00ff_0f12, 32'h00ca_0002};
    rows[1] = '{32'h0000_0103, REG_STATUS, 32'h00ff_0f12, 32'h00c0_0002};
    rows[2] = '{32'h0000_0105, REG_ID, 32'hffff_ffff, 32'hc0a5_3c5a};
    rows[3] = '{32'h0000_0107, REG_STATUS, 32'h0000_0002, 32'h0000_0002};
    rows[4] = '{32'h0000_0109, REG_STATUS, 32'h00ff_0f12, 32'h00ca_0002};
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    wb(1'b1, REG_CTRL, 32'h0000_0101, rd);
    wb(1'b0, REG_STATUS, 32'h0000_0000, rd);
    check(rd & 32'h0000_000a, 32'h0000_0000);
    for (i = 0; i < 600 && rd[ST_PWR_BIT] !== 1'b1; i++) wb(1'b0, REG_STATUS, 32'h0000_0000, rd);
    check(rd & 32'h0000_0008, 32'h0000_0008);
    for (i = 0; i < 5; i++) run(rows[i]);
    fail_en <= 1'b1;
    run('{32'h0000_0139, REG_STATUS, 32'h00ff_0f12, 32'h00c3_0112});
    fail_en <= 1'b0;
    wb(1'b1, REG_CTRL, 32'h0000_0109, rd);
    rd = '1;
    for (i = 0; i < 50 && rd[ST_RB_BIT] !== 1'b0; i++) wb(1'b0, REG_STATUS, 32'h0000_0000, rd);
    check(rd & 32'h0000_0005, 32'h0000_0001);
    run(rows[3]);
    run(rows[3]);
    run(rows[0]);
    wb(1'b1, REG_DST0, 32'h0000_2000, rd);
    run('{32'h0000_0109, REG_STATUS, 32'h0000_0022, 32'h0000_0022});
    wb(1'b0, 8'h40, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    stop_test();
  end
endmodule : nand_copyback_host_tb_top

bind nand_copyback_host nand_copyback_host_chk chk (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pins(pins), .rb(rb));

// ### nand_dev_model.sv
module nand_dev_model
  import nand_host_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5a,  // arbitrary value
  parameter logic [7:0] DEV_CODE   = 8'h3c   // arbitrary value
)(
  // clock, pins and fail injection
  input wire logic   sys_clk,
  input nand_pins_t  pins,
  input wire logic   fail_en,
  output logic [7:0] io_in,
  output logic       rb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  mode_reg = 2'h0;  // 0 array read after power-up
  logic [1:0]  idx_reg  = 2'h0;
  logic [7:0]  stat_reg = 8'hc0;
  logic [7:0]  busy_reg = 8'h00;
  logic        rbsy_reg = 1'b0;
  logic        we_d_reg = 1'b1;
  logic        re_d_reg = 1'b1;
  logic [7:0]  last_reg = 8'h00;
  logic [2:0]  acnt_reg = 3'h0;
  logic [31:0] id_w;
  assign id_w = {8'hc0, 8'ha5, DEV_CODE, MAKER_CODE};
  assign rb   = (busy_reg == 8'h00);

  // command decode on write strobe rise, busy countdown
  always @(posedge sys_clk) begin
    we_d_reg <= pins.we_n;
    re_d_reg <= pins.read_enable_n;
    last_reg <= io_in;
    if (busy_reg != 8'h00) busy_reg <= busy_reg - 8'h01;
    if (busy_reg == 8'h01) rbsy_reg <= 1'b0;
    if (pins.read_enable_n && !re_d_reg && mode_reg == 2'h3) idx_reg <= idx_reg + 2'h1;
    if (pins.we_n && !we_d_reg && pins.ale && acnt_reg != 3'h0) begin
      acnt_reg <= acnt_reg - 3'h1;
      if (acnt_reg == 3'h1) busy_reg <= 8'h20;
    end
    if (pins.we_n && !we_d_reg && !pins.ce_n && pins.cle) begin
      case (pins.io_out)
        CMD_STATUS:                  mode_reg <= 2'h1;
        CMD_STATUS_MP:               mode_reg <= 2'h2;
        CMD_READ_ID:                 mode_reg <= 2'h3;
        CMD_READ_MAIN, CMD_READ_ALT: acnt_reg <= 3'h4;
        CMD_PROG_DUMMY:              busy_reg <= 8'h04;
        CMD_PROG_CONFIRM: begin
          busy_reg <= 8'h40;
          stat_reg <= {pins.wp_n, 5'h00, fail_en, fail_en};
        end
        CMD_RESET: begin
          if (!rbsy_reg) begin
            busy_reg <= 8'h10;
            rbsy_reg <= 1'b1;
            mode_reg <= 2'h0;
            stat_reg <= pins.wp_n ? 8'hc0 : 8'h40;
          end
        end
        default: ;
      endcase
      if (pins.io_out == CMD_READ_ID) idx_reg <= 2'h0;
    end
  end

  // live read data; unread bus shows a changing pattern
  always_comb begin
    io_in = ~last_reg;
    if (!pins.ce_n && !pins.read_enable_n) begin
      case (mode_reg)
        2'h1: io_in = {stat_reg[7], rb, stat_reg[5], 4'b0101, stat_reg[0]};
        2'h2: io_in = {stat_reg[7], rb, stat_reg[5:0]};
        2'h3: io_in = id_w[{idx_reg, 3'b000} +: 8];
        default: io_in = ~last_reg;
      endcase
    end
  end
endmodule : nand_dev_model

// ### nand_host_pkg.sv
// What this block does
// - copy-back opens with normal read 00h and source address; page moves internally.
// - once ready after source read, send 8Ah and destination address cycles.
// - programming starts only after 10h follows the destination address.
// - source and destination must agree in A14, A15 and A26.
// - no partial page program into copied pages before their block is erased.
// - program failures show in pass/fail status; use two-bit error correction (this block does no error correction).
// - multi-plane: first source read uses 00h, later ones 03h; up to four planes.
// - non-final planes end with dummy 11h, last plane ends with 10h.
// - no area-pointer operation together with multi-plane copy-back.
// - status mode persists; issue a read command before resuming page reads.
// - use 71h for multi-plane, judge pass/fail only when ready.
// - 90h then address 00h gives four id bytes; mode holds until new command.
// - after power-up wait at least the recovery time before any command.
package nand_host_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_KHZ       = 50_000;
  localparam int unsigned PWR_RECOVERY_US   = 10;
  localparam int unsigned PWR_RECOVERY_CYC  = PWR_RECOVERY_US * SYS_CLK_KHZ / 1000;
  localparam int unsigned STROBE_NS         = 40;
  localparam int unsigned STROBE_CYC        = (STROBE_NS * SYS_CLK_KHZ + 999_999) / 1_000_000;
  localparam int unsigned BUSY_SETUP_NS     = 100;
  localparam int unsigned BUSY_SETUP_CYC    = (BUSY_SETUP_NS * SYS_CLK_KHZ + 999_999) / 1_000_000;
  localparam logic [9:0]  PWR_CNT_INIT      = 10'(PWR_RECOVERY_CYC - 1);
  localparam logic [9:0]  STROBE_CNT        = 10'(STROBE_CYC - 1);
  localparam logic [9:0]  BUSY_SETUP_CNT    = 10'(BUSY_SETUP_CYC - 1);

  // ----------------------------------------------------------------
  // flash commands
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_MAIN     = 8'h00;
  localparam logic [7:0] CMD_READ_ALT      = 8'h03;
  localparam logic [7:0] CMD_COPY_DATA_IN  = 8'h8A;
  localparam logic [7:0] CMD_PROG_CONFIRM  = 8'h10;
  localparam logic [7:0] CMD_PROG_DUMMY    = 8'h11;
  localparam logic [7:0] CMD_STATUS        = 8'h70;
  localparam logic [7:0] CMD_STATUS_MP     = 8'h71;
  localparam logic [7:0] CMD_READ_ID       = 8'h90;
  localparam logic [7:0] CMD_RESET         = 8'hFF;
  localparam logic [7:0] ID_ADDR           = 8'h00;
  localparam logic [7:0] STATUS_AFTER_RST  = 8'hC0;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL          = 8'h00;
  localparam logic [7:0] REG_STATUS        = 8'h04;
  localparam logic [7:0] REG_ID            = 8'h08;
  localparam logic [7:0] REG_SRC0          = 8'h10;
  localparam logic [7:0] REG_DST0          = 8'h20;
  localparam int         CTRL_START_BIT    = 0;
  localparam int         CTRL_OP_LSB       = 1;
  localparam int         CTRL_PLANES_LSB   = 4;
  localparam int         CTRL_WP_BIT       = 8;
  localparam int         ST_BUSY_BIT       = 0;
  localparam int         ST_DONE_BIT       = 1;
  localparam int         ST_RB_BIT         = 2;
  localparam int         ST_PWR_BIT        = 3;
  localparam int         ST_FAIL_BIT       = 4;
  localparam int         ST_PLANE_ERR_BIT  = 5;
  localparam int         ST_PFAIL_LSB      = 8;
  localparam int         ST_BYTE_LSB       = 16;
  localparam int         NST_FAIL          = 0;
  localparam int         NST_PFAIL_LSB     = 1;
  localparam int         ADDR_A14          = 13;
  localparam int         ADDR_A15          = 14;
  localparam int         ADDR_A26          = 25;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_STATUS    = 3'h0,
    OP_STATUS_MP = 3'h1,
    OP_READ_ID   = 3'h2,
    OP_RESET     = 3'h3,
    OP_COPYBACK  = 3'h4
  } op_t;

  typedef enum logic [2:0] {
    ST_PWR  = 3'b000,
    ST_IDLE = 3'b001,
    ST_NEXT = 3'b011,
    ST_WR   = 3'b010,
    ST_WRH  = 3'b110,
    ST_RD   = 3'b111,
    ST_RDH  = 3'b101,
    ST_WAIT = 3'b100
  } seq_state_t;

  typedef enum logic [3:0] {
    S_SRC_CMD  = 4'h0,
    S_SRC_ADDR = 4'h1,
    S_SRC_WAIT = 4'h2,
    S_DST_CMD  = 4'h3,
    S_DST_ADDR = 4'h4,
    S_DST_CONF = 4'h5,
    S_DST_WAIT = 4'h6,
    S_STAT_CMD = 4'h7,
    S_STAT_RD  = 4'h8,
    S_ID_CMD   = 4'h9,
    S_ID_ADDR  = 4'hA,
    S_ID_RD    = 4'hB,
    S_RST_CMD  = 4'hC,
    S_RST_WAIT = 4'hD,
    S_FINISH   = 4'hE
  } step_t;

  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       ce_n;
    logic       we_n;
    logic       read_enable_n;
    logic       wp_n;
    logic       io_oe;
    logic [7:0] io_out;
  } nand_pins_t;

  localparam nand_pins_t PINS_IDLE = '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
                                       read_enable_n: 1'b1, wp_n: 1'b0, io_oe: 1'b0, io_out: 8'h00};

  typedef struct packed {
    seq_state_t       st;
    step_t            step;
    op_t              op;
    logic [1:0]       plane;
    logic [1:0]       last_plane;
    logic [1:0]       byte_i;
    logic [9:0]       cnt;
    logic             multi;
    logic             wp_rel;
    logic             pwr_ok;
    logic             done;
    logic             plane_err;
    logic [3:0][31:0] src;
    logic [3:0][31:0] dst;
    logic [31:0]      id;
    logic [7:0]       stat_byte;
    nand_pins_t       pins;
    logic             ack;
    logic [31:0]      dat;
  } ctl_state_t;

endpackage : nand_host_pkg
